/* File: hdl/cssq_pkg.sv */
// constants for the configuration startup sequencer
`default_nettype none
package cssq_pkg;
    localparam int CLK_MHZ = 100;
    // register byte offsets
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_RATE = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_FRAME = 8'h0c;
    localparam logic [7:0] OFS_FDATA = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // cfg field positions
    localparam int F_DONE = 0;
    localparam int F_IOREL = 4;
    localparam int F_WREN = 8;
    localparam int F_LOCK = 12;
    localparam int F_MATCH = 16;
    localparam int F_CLK = 20;
    localparam int F_RESYNC = 24;
    localparam int F_DRIVE = 25;
    localparam int F_SHDN = 26;
    localparam int F_SEC = 27;
    localparam int F_PERSIST = 29;
    // cmd bits
    localparam int C_SHUTDOWN = 0;
    localparam int C_ALL_OUTPUTS_HIGH_CMD = 1;
    // frame reg fields
    localparam int F_FADDR = 0;
    localparam int F_FCNT = 16;
    // reset values
    localparam logic [2:0] RST_DONE_PH = 3'h4;
    localparam logic [2:0] RST_IOREL_PH = 3'h5;
    localparam logic [2:0] RST_WREN_PH = 3'h6;
    localparam logic [31:0] RST_CFG = 32'h0007_7654;
    localparam logic [4:0] RST_RATE = 5'h00;
    // phase select codes
    localparam logic [2:0] SEL_ON_DONE = 3'h0;
    localparam logic [2:0] SEL_KEEP = 3'h7;
    localparam logic [2:0] SEL_NOWAIT = 3'h7;
    localparam logic [2:0] PH_LAST = 3'h6;
    localparam logic [2:0] PH_DONE = 3'h7;
    // security levels
    localparam logic [1:0] SEC_NONE = 2'h0;
    localparam logic [1:0] SEC_L2 = 2'h2;
    // mode pin codes of the master modes
    localparam logic [2:0] MODE_MSER = 3'h0;
    localparam logic [2:0] MODE_MPAR = 3'h3;
    // cclk rates in MHz
    localparam int NUM_RATES = 17;
    localparam logic [5:0] RATE_MHZ [0:16] = '{
        6'h04, 6'h05, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0d, 6'h0f,
        6'h14, 6'h1a, 6'h1e, 6'h22, 6'h29, 6'h2d, 6'h33, 6'h37,
        6'h3c};
    typedef enum logic [1:0] {
        CSSQ_SRC_CCLK = 2'b00,
        CSSQ_SRC_FABRIC = 2'b01,
        CSSQ_SRC_TAP = 2'b10
    } cssq_src_t;
    typedef enum logic [1:0] {
        CSSQ_IDLE = 2'b00,
        CSSQ_RUN = 2'b01,
        CSSQ_DONE = 2'b10
    } cssq_state_t;
endpackage : cssq_pkg
`default_nettype wire

/* File: hdl/cssq_top.sv */
// configuration startup sequencer with wishbone registers
//
// Summary of operation
// - done released in programmable phase zero to seven, default four
// - with resync, wait for sensed done high, then one edge more
// - io three-state released at phase, on sensed done, or kept
// - sensed done is the pin, or its delayed copy under resync
// - global write enable asserted at phase six default, or on done
// - block ram reads and writes blocked until write enable phase
// - keep setting leaves global write enable at its current value
// - stall in selected phase until clock managers lock; default none
// - stall in selected phase until impedance match; default none
// - sequencer clocked by cclk, fabric clock or tap clock
// - master modes make cclk internally at selectable rate 4 to 60, never faster than clk_i / 2
// - active drive option drives the done pin high
// - clock managers reset after shutdown and outputs-high commands
// - level one blocks readback; level two also partial reconfig
// - persist keeps parallel config pins dedicated after startup
// - multiple frame write loads one data word into many frames
// - configuration mode taken from three mode pins
// - tap clock sequences tap controller and startup alike
//
// Decided for this implementation: the Wishbone slave port and the address map.
`default_nettype none
module cssq_top
    import cssq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] mode_pin_i,
    input wire logic config_complete_i,
    input wire logic cclk_pin_i,
    output logic cclk_pin_o,
    output logic cclk_pin_oe_o,
    input wire logic fabric_clk_i,
    input wire logic tap_clk_i,
    output logic tap_step_o,
    input wire logic done_pin_i,
    output logic done_pin_o,
    output logic done_pin_oe_o,
    input wire logic clkmgr_locked_i,
    input wire logic imp_match_i,
    output logic global_tristate_o,
    output logic global_write_en_o,
    output logic block_ram_en_o,
    output logic clkmgr_reset_o,
    output logic readback_en_o,
    output logic partial_reconfig_en_o,
    output logic parallel_port_keep_o,
    output logic frame_we_o,
    output logic [15:0] frame_addr_o,
    output logic [31:0] frame_data_o
);
    // =========================================================
    // register bus
    logic [31:0] cfg;
    logic [4:0] rate_idx;
    logic [31:0] fdata;
    logic [31:0] status;
    logic ack;
    logic bus_req;
    logic wr_fire;
    logic shut_seen;
    logic agh_seen;
    logic [15:0] mfw_addr;
    logic [7:0] mfw_left;
    logic [2:0] mode_q;
    logic mode_taken;
    logic is_master;
    cssq_state_t state;
    logic [2:0] ph;
    logic done_rel;
    logic done_pipe;
    logic done_seen;
    logic done_sense;
    logic global_tristate;
    logic global_write_en;
    logic [2:0] done_sel;
    logic [2:0] iorel_sel;
    logic [2:0] wren_sel;
    logic [2:0] lock_sel;
    logic [2:0] match_sel;
    logic [1:0] sec;

    assign bus_req = wb_cyc_i & wb_stb_i;
    // a write lands on the edge where the master sees ack
    assign wr_fire = bus_req & wb_we_i & ack;
    assign wb_ack_o = ack;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack <= 1'b0;
        end else if (ce_i) begin
            ack <= bus_req & ~ack;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg <= RST_CFG;
            rate_idx <= RST_RATE;
            fdata <= 32'h0000_0000;
        end else if (ce_i && wr_fire) begin
            case (wb_adr_i)
                OFS_CFG: cfg <= merge(cfg, wb_dat_i, wb_sel_i);
                OFS_RATE: begin
                    if (wb_sel_i[0]) begin
                        rate_idx <= wb_dat_i[4:0];
                    end
                end
                OFS_FDATA: fdata <= merge(fdata, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i && bus_req && !ack) begin
            case (wb_adr_i)
                OFS_CFG: wb_dat_o <= cfg;
                OFS_RATE: wb_dat_o <= {27'h0000000, rate_idx};
                OFS_FRAME: wb_dat_o <= {8'h00, mfw_left, mfw_addr};
                OFS_FDATA: wb_dat_o <= fdata;
                OFS_STAT: wb_dat_o <= status;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    assign done_sel = cfg[F_DONE +: 3];
    assign iorel_sel = cfg[F_IOREL +: 3];
    assign wren_sel = cfg[F_WREN +: 3];
    assign lock_sel = cfg[F_LOCK +: 3];
    assign match_sel = cfg[F_MATCH +: 3];
    assign sec = cfg[F_SEC +: 2];

    assign status = {16'h0000, is_master, (mfw_left != 8'h00), mode_q,
                     imp_match_i, clkmgr_locked_i, done_rel, done_sense,
                     global_write_en, global_tristate, state, ph};

    // =========================================================
    // mode pins and internal cclk
    // pins are caught by a clocked process after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_taken <= 1'b0;
        end else if (ce_i && !mode_taken) begin
            mode_taken <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (ce_i && !mode_taken) begin
            mode_q <= mode_pin_i;
        end
    end

    assign is_master = mode_taken &&
                       (mode_q == MODE_MSER || mode_q == MODE_MPAR);

    // rates above half the system clock saturate at clk_i / 2
    function automatic logic [7:0] half_period(input logic [4:0] idx);
        int h;
        h = (idx < 5'(NUM_RATES)) ? CLK_MHZ / (2 * int'(RATE_MHZ[idx]))
                                  : CLK_MHZ / (2 * int'(RATE_MHZ[0]));
        if (h < 1) begin
            h = 1;
        end
        return 8'(h);
    endfunction : half_period

    logic [7:0] cclk_cnt;
    logic cclk_int;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cclk_cnt <= 8'h00;
            cclk_int <= 1'b0;
        end else if (ce_i) begin
            if (cclk_cnt >= half_period(rate_idx) - 8'h01) begin
                cclk_cnt <= 8'h00;
                cclk_int <= ~cclk_int;
            end else begin
                cclk_cnt <= cclk_cnt + 8'h01;
            end
        end
    end

    assign cclk_pin_o = cclk_int;
    assign cclk_pin_oe_o = is_master;

    // =========================================================
    // sequencer clock select
    logic src_now;
    logic src_prev;
    logic tap_prev;
    logic seq_tick;

    always_comb begin
        case (cssq_src_t'(cfg[F_CLK +: 2]))
            CSSQ_SRC_CCLK: src_now = is_master ? cclk_int : cclk_pin_i;
            CSSQ_SRC_FABRIC: src_now = fabric_clk_i;
            CSSQ_SRC_TAP: src_now = tap_clk_i;
            default: src_now = is_master ? cclk_int : cclk_pin_i;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev <= 1'b0;
            tap_prev <= 1'b0;
        end else if (ce_i) begin
            src_prev <= src_now;
            tap_prev <= tap_clk_i;
        end
    end

    assign seq_tick = src_now & ~src_prev;
    // the tap controller steps on the same edges
    assign tap_step_o = tap_clk_i & ~tap_prev;

    // =========================================================
    // phase sequencer
    logic stall;

    assign stall = (lock_sel == ph && !clkmgr_locked_i) ||
                   (match_sel == ph && !imp_match_i);
    assign done_sense = cfg[F_RESYNC] ? done_pipe : done_pin_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_pipe <= 1'b0;
        end else if (ce_i && seq_tick) begin
            done_pipe <= done_pin_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= CSSQ_IDLE;
            ph <= 3'h0;
            done_seen <= 1'b0;
        end else if (ce_i && seq_tick) begin
            case (state)
                CSSQ_IDLE: begin
                    if (config_complete_i) begin
                        state <= CSSQ_RUN;
                        ph <= 3'h0;
                    end
                end
                CSSQ_RUN: begin
                    if (stall) begin
                        ph <= ph;
                    end else if (ph != PH_LAST) begin
                        ph <= ph + 3'h1;
                    end else if (!cfg[F_RESYNC] || done_seen) begin
                        state <= CSSQ_DONE;
                        ph <= PH_DONE;
                    end else if (done_sense) begin
                        done_seen <= 1'b1;
                    end
                end
                CSSQ_DONE: ph <= PH_DONE;
                default: begin
                    state <= CSSQ_IDLE;
                    ph <= 3'h0;
                end
            endcase
        end
    end

    // =========================================================
    // done pin, io release, write enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_rel <= 1'b0;
        end else if (ce_i) begin
            done_rel <= (state != CSSQ_IDLE) && ph >= done_sel;
        end
    end

    // low until released; then float or, with drive, push high
    assign done_pin_o = done_rel;
    assign done_pin_oe_o = ~done_rel | cfg[F_DRIVE];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_tristate <= 1'b1;
        end else if (ce_i && state != CSSQ_IDLE) begin
            case (iorel_sel)
                SEL_ON_DONE: begin
                    if (done_sense) begin
                        global_tristate <= 1'b0;
                    end
                end
                SEL_KEEP: global_tristate <= global_tristate;
                default: begin
                    if (ph >= iorel_sel) begin
                        global_tristate <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_write_en <= 1'b0;
        end else if (ce_i && state != CSSQ_IDLE) begin
            case (wren_sel)
                SEL_ON_DONE: begin
                    if (done_sense) begin
                        global_write_en <= 1'b1;
                    end
                end
                SEL_KEEP: global_write_en <= global_write_en;
                default: begin
                    if (ph >= wren_sel) begin
                        global_write_en <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign global_tristate_o = global_tristate;
    assign global_write_en_o = global_write_en;
    assign block_ram_en_o = global_write_en;

    // =========================================================
    // clock manager shutdown
    logic cmd_wr;

    assign cmd_wr = wr_fire && wb_adr_i == OFS_CMD && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shut_seen <= 1'b0;
            agh_seen <= 1'b0;
            clkmgr_reset_o <= 1'b0;
        end else if (ce_i) begin
            clkmgr_reset_o <= cfg[F_SHDN] && shut_seen && agh_seen;
            // a command landing in the clearing cycle still counts
            if (cfg[F_SHDN] && shut_seen && agh_seen) begin
                shut_seen <= cmd_wr && wb_dat_i[C_SHUTDOWN];
                agh_seen <= cmd_wr && wb_dat_i[C_ALL_OUTPUTS_HIGH_CMD];
            end else if (cmd_wr) begin
                shut_seen <= shut_seen | wb_dat_i[C_SHUTDOWN];
                agh_seen <= agh_seen | wb_dat_i[C_ALL_OUTPUTS_HIGH_CMD];
            end
        end
    end

    // =========================================================
    // security and persistence
    assign readback_en_o = (sec == SEC_NONE);
    assign partial_reconfig_en_o = (sec < SEC_L2);
    assign parallel_port_keep_o = cfg[F_PERSIST];

    // =========================================================
    // multiple frame write
    // one data word is repeated into consecutive frames; a single
    // count of one gives the per-frame load a debug stream uses
    logic mfw_start;

    assign mfw_start = wr_fire && wb_adr_i == OFS_FRAME &&
                       mfw_left == 8'h00 && partial_reconfig_en_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mfw_addr <= 16'h0000;
            mfw_left <= 8'h00;
            frame_we_o <= 1'b0;
            frame_addr_o <= 16'h0000;
            frame_data_o <= 32'h0000_0000;
        end else if (ce_i) begin
            frame_we_o <= 1'b0;
            if (mfw_start) begin
                mfw_addr <= wb_dat_i[F_FADDR +: 16];
                mfw_left <= wb_dat_i[F_FCNT +: 8];
            end else if (mfw_left != 8'h00) begin
                frame_we_o <= 1'b1;
                frame_addr_o <= mfw_addr;
                frame_data_o <= fdata;
                mfw_addr <= mfw_addr + 16'h0001;
                mfw_left <= mfw_left - 8'h01;
            end
        end
    end
endmodule : cssq_top
`default_nettype wire

/* File: verif/cssq_monitor.sv */
// port-level assertions for the startup sequencer
`default_nettype none
module cssq_monitor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_ack_o,
    input wire logic done_pin_o,
    input wire logic global_tristate_o,
    input wire logic global_write_en_o,
    input wire logic block_ram_en_o,
    input wire logic clkmgr_reset_o,
    input wire logic frame_we_o,
    input wire logic [15:0] frame_addr_o,
    input wire logic [31:0] frame_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========
    // sequences
    sequence s_run;
        frame_we_o ##1 frame_we_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // ==========
    // assertions
    a_ack_one_cycle: assert property (wb_ack_o |-> s_ack)
        else $error("ack longer than one cycle");
    a_io_stays_free: assert property (
        !global_tristate_o |=> !global_tristate_o)
        else $error("io three-state came back");
    a_wren_stays_on: assert property (
        $rose(global_write_en_o) |=> global_write_en_o [*8])
        else $error("write enable dropped");
    a_block_ram_gated: assert property (
        block_ram_en_o == global_write_en_o)
        else $error("block ram enable apart from write enable");
    a_done_stays: assert property (done_pin_o |=> done_pin_o)
        else $error("done withdrawn");
    a_cm_reset_pulse: assert property (
        clkmgr_reset_o |=> !clkmgr_reset_o)
        else $error("clock manager reset too long");
    a_frame_addr_step: assert property (
        s_run |-> frame_addr_o == $past(frame_addr_o) + 16'h1)
        else $error("frame address not stepping by one");
    a_frame_data_same: assert property (
        s_run |-> $stable(frame_data_o))
        else $error("frame data changed within a run");
endmodule : cssq_monitor
bind cssq_top cssq_monitor u_mon (
    .clk_i, .rst_i, .wb_ack_o, .done_pin_o, .global_tristate_o,
    .global_write_en_o, .block_ram_en_o, .clkmgr_reset_o, .frame_we_o,
    .frame_addr_o, .frame_data_o
);
`default_nettype wire

/* File: verif/cssq_partner.sv */
// far side of the done pin: pull-up and a chained device
`default_nettype none
module cssq_partner (
    input wire logic done_pin_o,
    input wire logic done_pin_oe_o,
    input wire logic hold_low_i,
    output logic done_wire_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========
    // wired done line
    // open drain with pull-up, so any party driving low wins
    assign done_wire_o = !(hold_low_i ||
                           (done_pin_oe_o && !done_pin_o));
endmodule : cssq_partner
`default_nettype wire

/* File: verif/cssq_top_bench.sv */
// self-checking bench for the startup sequencer
`default_nettype none
module cssq_top_bench
    import cssq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, rst_i = 1, ce_i = 1, config_complete_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, frame_data_o;
    logic [2:0] mode_pin_i = 3'h7, src_en = 3'h1;
    logic seq_clk = 0, hold = 0, clkmgr_locked_i = 0, imp_match_i = 0;
    logic cclk_pin_i, fabric_clk_i, tap_clk_i, done_pin_i, cclk_pin_o;
    logic cclk_pin_oe_o, tap_step_o, done_pin_o, done_pin_oe_o;
    logic global_tristate_o, global_write_en_o, block_ram_en_o;
    logic clkmgr_reset_o, readback_en_o, partial_reconfig_en_o;
    logic parallel_port_keep_o, frame_we_o;
    logic [15:0] frame_addr_o, fq[$];
    int n_mismatch = 0, n_tests = 0, n_cm = 0, n_tap = 0;
    // sequencer ticks reach only the enabled source input
    assign cclk_pin_i = seq_clk & src_en[0];
    assign fabric_clk_i = seq_clk & src_en[1];
    assign tap_clk_i = seq_clk & src_en[2];
    cssq_top dut (
        .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mode_pin_i,
        .config_complete_i, .cclk_pin_i, .cclk_pin_o, .cclk_pin_oe_o,
        .fabric_clk_i, .tap_clk_i, .tap_step_o, .done_pin_i, .done_pin_o,
        .done_pin_oe_o, .clkmgr_locked_i, .imp_match_i, .global_tristate_o,
        .global_write_en_o, .block_ram_en_o, .clkmgr_reset_o,
        .readback_en_o, .partial_reconfig_en_o, .parallel_port_keep_o,
        .frame_we_o, .frame_addr_o, .frame_data_o
    );
    cssq_partner chain (
        .done_pin_o, .done_pin_oe_o, .hold_low_i(hold),
        .done_wire_o(done_pin_i)
    );
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (clkmgr_reset_o === 1'b1) n_cm++;
        if (tap_step_o === 1'b1) n_tap++;
        if (frame_we_o === 1'b1) fq.push_back(frame_addr_o);
    end
    // ==========
    // helpers
    task automatic chk(input string nm, input logic [31:0] e, s);
        n_tests++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic do_reset(input logic [2:0] m);
        rst_i <= 1'b1;
        mode_pin_i <= m;
        config_complete_i <= 1'b0;
        {hold, clkmgr_locked_i, imp_match_i} <= 3'h0;
        src_en <= 3'h1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic start(input logic [31:0] cfg);
        do_reset(3'h7);
        wb(1'b1, OFS_CFG, cfg);
        config_complete_i <= 1'b1;
    endtask : start
    // slow enough that every output has settled when it returns
    task automatic tick(input int n);
        repeat (n) begin
            seq_clk <= 1'b1;
            repeat (3) @(posedge clk_i);
            seq_clk <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask : tick
    task automatic gap(output int k);
        logic v;
        v = cclk_pin_o;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (cclk_pin_o === v && k < 100);
        if (cclk_pin_o === v) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : gap
    // ==========
    // scenarios
    task automatic t_base();
        wb(1'b0, OFS_CFG, 32'h0);
        chk("cfg", RST_CFG, q);
        wb(1'b1, 8'h40, 32'hffff_ffff);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("slave cclk oe", 0, cclk_pin_oe_o);
        chk("readback", 1, readback_en_o);
        chk("persist", 0, parallel_port_keep_o);
        config_complete_i <= 1'b1;
        for (int n = 0; n < 8; n++) begin
            tick(1);
            chk("done", n >= 4, done_pin_o);
            chk("io held", n < 5, global_tristate_o);
            chk("wren", n >= 6, global_write_en_o);
            chk("block_ram", n >= 6, block_ram_en_o);
        end
        chk("done oe", 0, done_pin_oe_o);
    endtask : t_base
    task automatic t_stall(input int f);
        start(RST_CFG & ~(32'h7 << f) | (32'h2 << f));
        tick(8);
        wb(1'b0, OFS_STAT, 32'h0);
        chk("stall phase", 2, q[2:0]);
        if (f == F_LOCK) clkmgr_locked_i <= 1'b1;
        else imp_match_i <= 1'b1;
        // with the clock enable low no tick may move the phase
        ce_i <= 1'b0;
        tick(2);
        chk("frozen", 0, done_pin_o);
        ce_i <= 1'b1;
        tick(1);
        chk("done early", 0, done_pin_o);
        tick(1);
        chk("resumed", 1, done_pin_o);
    endtask : t_stall
    task automatic t_pipe();
        start(32'h0307_7004);
        hold <= 1'b1;
        tick(8);
        chk("drive high", 1, done_pin_oe_o);
        chk("io on done", 1, global_tristate_o);
        chk("wren on done", 0, global_write_en_o);
        hold <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("sense delayed", 1, global_tristate_o);
        tick(1);
        chk("io free", 0, global_tristate_o);
        chk("wren set", 1, global_write_en_o);
        wb(1'b0, OFS_STAT, 32'h0);
        chk("not done", CSSQ_RUN, q[4:3]);
        tick(2);
        wb(1'b0, OFS_STAT, 32'h0);
        chk("done state", CSSQ_DONE, q[4:3]);
    endtask : t_pipe
    task automatic t_keep();
        start(32'h0007_7774);
        tick(8);
        chk("io keep", 1, global_tristate_o);
        chk("wren keep", 0, block_ram_en_o);
    endtask : t_keep
    task automatic t_src();
        for (int s = 0; s < 3; s++) begin
            start(RST_CFG | (32'(s) << F_CLK));
            src_en <= 3'h1 << ((s + 1) % 3);
            tick(8);
            chk("wrong source", 0, done_pin_o);
            src_en <= 3'h1 << s;
            n_tap = 0;
            tick(5);
            chk("right source", 1, done_pin_o);
            chk("tap steps", s == 2 ? 5 : 0, n_tap);
        end
    endtask : t_src
    task automatic t_regs();
        for (int e = 0; e < 2; e++) begin
            start(RST_CFG | (32'(e) << F_SHDN));
            n_cm = 0;
            wb(1'b1, OFS_CMD, 32'h1);
            wb(1'b1, OFS_CMD, 32'h2);
            repeat (4) @(posedge clk_i);
            chk("clkmgr reset", e, n_cm);
        end
        fq.delete();
        wb(1'b1, OFS_FDATA, 32'h5a5a_c3c3);
        wb(1'b1, OFS_FRAME, 32'h0003_fffe);
        repeat (8) @(posedge clk_i);
        chk("frames", 3, fq.size());
        for (int i = 0; i < fq.size(); i++) begin
            chk("frame addr", 16'(16'hfffe + i), fq[i]);
        end
        chk("frame data", 32'h5a5a_c3c3, frame_data_o);
        // debug-style load: zero word, then a single frame with a count of one
        fq.delete();
        wb(1'b1, OFS_FDATA, 32'h0);
        wb(1'b1, OFS_FRAME, 32'h0001_0010);
        repeat (4) @(posedge clk_i);
        chk("single frame", 1, fq.size());
        chk("single addr", 16'h0010, fq[0]);
        chk("zero word", 32'h0, frame_data_o);
        for (int s = 0; s < 3; s++) begin
            wb(1'b1, OFS_CFG, RST_CFG | (32'(s) << F_SEC) | 32'h2000_0000);
            chk("readback", s == 0, readback_en_o);
            chk("partial", s != 2, partial_reconfig_en_o);
            chk("persist", 1, parallel_port_keep_o);
        end
        fq.delete();
        wb(1'b1, OFS_FRAME, 32'h0002_0000);
        repeat (8) @(posedge clk_i);
        chk("frames refused", 0, fq.size());
    endtask : t_regs
    task automatic t_rate();
        int k;
        do_reset(MODE_MPAR);
        repeat (2) @(posedge clk_i);
        chk("parallel master oe", 1, cclk_pin_oe_o);
        do_reset(MODE_MSER);
        wb(1'b1, OFS_RATE, 32'h5);
        chk("master cclk oe", 1, cclk_pin_oe_o);
        repeat (2) gap(k);
        chk("half period", 5, k);
        wb(1'b1, OFS_RATE, 32'h10);
        repeat (2) gap(k);
        chk("half period max", 1, k);
    endtask : t_rate
    initial begin
        do_reset(3'h7);
        t_base();
        t_stall(F_LOCK);
        t_stall(F_MATCH);
        t_pipe();
        t_keep();
        t_src();
        t_regs();
        t_rate();
        give_verdict();
    end
endmodule : cssq_top_bench
`default_nettype wire
